// ==== src/vpc_pkg.sv ====
// vpc_pkg: shared constants of the voltage pwm chopper control block
// assumes: a single 200 MHz system clock domain
package vpc_pkg;
    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int          THR_W         = 20;
    localparam int          CORR_W        = 9;
    // ----------------------------------------
    // reset and limit values
    // ----------------------------------------
    localparam logic [19:0] STEP_CNT_MAX  = 20'hFFFFF;
    localparam logic [3:0]  LIM_RESET     = 4'hC;
    localparam logic [3:0]  LIM_LOW_FILL  = 4'hF;
    localparam logic [7:0]  SCALE_MAX     = 8'hFF;
    localparam logic [7:0]  GRAD_RESET    = 8'h0E;
    localparam logic [7:0]  OFS_RESET     = 8'h24;
    localparam logic [9:0]  CORR2_MAX     = 10'h1FE;
    localparam logic [9:0]  CORR2_MIN     = 10'h202;
    // ----------------------------------------
    // pwm period in half clock units, indexed by frequency select
    // ----------------------------------------
    localparam logic [10:0] PWM_DIV_0     = 11'h400;
    localparam logic [10:0] PWM_DIV_1     = 11'h2AB;
    localparam logic [10:0] PWM_DIV_2     = 11'h200;
    localparam logic [10:0] PWM_DIV_3     = 11'h19A;
    localparam logic [10:0] PWM_ACC_STEP  = 11'h002;
    // ----------------------------------------
    // blank time: base plus step per select code, in clock cycles
    // ----------------------------------------
    localparam logic [5:0]  BLANK_BASE    = 6'h10;
    localparam logic [5:0]  BLANK_STEP    = 6'h08;
    // ----------------------------------------
    // standstill codes
    // ----------------------------------------
    localparam logic [1:0]  SS_NORMAL     = 2'h0;
    localparam logic [1:0]  SS_STANDSTILL_OPTION  = 2'h1;
    localparam logic [1:0]  SS_SHORT_LS   = 2'h2;
    localparam logic [1:0]  SS_SHORT_HS   = 2'h3;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int          CLK_MHZ       = 200;
    localparam int          PD_TICK_US    = 1000;
    localparam int          PD_TICK_CYC   = PD_TICK_US * CLK_MHZ;
    localparam logic [2:0]  OL_FULLSTEPS  = 3'h4;
    typedef enum logic [1:0] {
        VPC_VOLT = 2'b01,
        VPC_CURR = 2'b10
    } vpc_mode_t;
endpackage

// ==== src/vpc_pwm_timer.sv ====
// vpc_pwm_timer: chopper period generator with fractional period support
// assumes: select is stable apart from changes taken at a period boundary
`timescale 1ns/1ps
module vpc_pwm_timer
    import vpc_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       rst_in,
    input  wire logic [1:0] pwm_frequency_select_in,
    output logic            boundary_out,
    output logic            chopper_out
);
    logic [10:0] acc_q;
    logic [10:0] div_q;
    logic [10:0] div_d;
    logic        tog_q;

    // counting by two in half-clock units makes 683/2 exact on average
    always_comb
    begin
        div_d = PWM_DIV_0;
        case (pwm_frequency_select_in)
            2'h1: div_d = PWM_DIV_1;
            2'h2: div_d = PWM_DIV_2;
            2'h3: div_d = PWM_DIV_3;
            default: div_d = PWM_DIV_0;
        endcase
    end

    assign boundary_out = (acc_q + PWM_ACC_STEP) >= div_q;

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            acc_q <= 11'h000;
            div_q <= PWM_DIV_0;
        end
        else if (boundary_out)
        begin
            acc_q <= acc_q + PWM_ACC_STEP - div_q;
            div_q <= div_d;
        end
        else
        begin
            acc_q <= acc_q + PWM_ACC_STEP;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            tog_q <= 1'b0;
        else if (boundary_out)
            tog_q <= ~tog_q;
    end

    assign chopper_out = tog_q;
endmodule // vpc_pwm_timer

// ==== src/vpc_blank_timer.sv ====
// vpc_blank_timer: masks the current comparator after each switching event
// assumes: trigger is a one-cycle pulse in the system clock domain
`timescale 1ns/1ps
module vpc_blank_timer
    import vpc_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       rst_in,
    input  wire logic       trigger_in,
    input  wire logic [1:0] blank_time_select_in,
    output logic            blank_out
);
    logic [5:0] cnt_q;

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            cnt_q <= 6'h00;
        else if (trigger_in)
            cnt_q <= BLANK_BASE + BLANK_STEP * {4'h0, blank_time_select_in};
        else if (cnt_q != 6'h00)
            cnt_q <= cnt_q - 6'h01;
    end

    assign blank_out = cnt_q != 6'h00;

    blank_len_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        trigger_in |=> blank_out [*8])
        else $error("blank window shorter than minimum");
endmodule // vpc_blank_timer

// ==== src/vpc_chopper_ctrl.sv ====
// vpc_chopper_ctrl: mode selection, amplitude scaling and status of a
// voltage pwm stepper chopper
// assumes: step and spread come from pins; all other inputs are synchronous
`timescale 1ns/1ps
module vpc_chopper_ctrl
    import vpc_pkg::*;
#(
    parameter int          PD_TICK    = PD_TICK_CYC,
    parameter logic [7:0]  GRAD_INIT  = GRAD_RESET
)
(
    input  wire logic              ref_clk_in,
    input  wire logic              rst_in,
    input  wire logic              global_spread_cfg_in,
    input  wire logic              spread_pin_in,
    input  wire logic              step_pin_in,
    input  wire logic              fullstep_in,
    input  wire logic [THR_W-1:0]  mode_switch_threshold_in,
    input  wire logic [3:0]        amplitude_limit_in,
    input  wire logic              autoscale_in,
    input  wire logic              autograd_in,
    input  wire logic [1:0]        pwm_frequency_select_in,
    input  wire logic [3:0]        regulation_gradient_in,
    input  wire logic [7:0]        amplitude_offset_in,
    input  wire logic [7:0]        amplitude_gradient_in,
    input  wire logic [1:0]        standstill_option_in,
    input  wire logic [4:0]        hold_current_in,
    input  wire logic [4:0]        current_setting_in,
    input  wire logic              target_current_zero_in,
    input  wire logic [7:0]        power_down_delay_in,
    input  wire logic [3:0]        hold_ramp_delay_in,
    input  wire logic [3:0]        off_time_setting_in,
    input  wire logic [1:0]        blank_time_select_in,
    input  wire logic [1:0]        coil_below_target_in,
    input  wire logic [1:0]        coil_interrupted_in,
    output logic                   current_mode_out,
    output logic                   driver_enable_out,
    output logic                   chopper_out,
    output logic                   blank_out,
    output logic [1:0]             standstill_out,
    output logic                   open_load_coil_a_out,
    output logic                   open_load_coil_b_out,
    output logic [CORR_W-1:0]      scale_correction_out,
    output logic [7:0]             tuned_gradient_readback_out,
    output logic [7:0]             tuned_offset_readback_out,
    output logic [7:0]             scale_sum_out,
    output logic [7:0]             pwm_amplitude_out,
    output logic [THR_W-1:0]       step_interval_count_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [1:0] spread_sync_q;
    logic [2:0] step_sync_q;
    logic       step_evt;

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            spread_sync_q <= 2'b00;
            step_sync_q   <= 3'b000;
        end
        else
        begin
            spread_sync_q <= {spread_sync_q[0], spread_pin_in};
            step_sync_q   <= {step_sync_q[1:0], step_pin_in};
        end
    end

    assign step_evt = step_sync_q[1] & ~step_sync_q[2];

    // ----------------------------------------
    // chopper timing
    // ----------------------------------------
    logic boundary;

    vpc_pwm_timer u_pwm (
        .ref_clk_in              (ref_clk_in),
        .rst_in                  (rst_in),
        .pwm_frequency_select_in (pwm_frequency_select_in),
        .boundary_out            (boundary),
        .chopper_out             (chopper_out)
    );

    vpc_blank_timer u_blank (
        .ref_clk_in           (ref_clk_in),
        .rst_in               (rst_in),
        .trigger_in           (boundary),
        .blank_time_select_in (blank_time_select_in),
        .blank_out            (blank_out)
    );

    // ----------------------------------------
    // step interval measurement
    // ----------------------------------------
    logic [THR_W-1:0] since_step_q;
    logic [THR_W-1:0] interval_q;

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            since_step_q <= STEP_CNT_MAX;
            interval_q   <= STEP_CNT_MAX;
        end
        else if (step_evt)
        begin
            interval_q   <= since_step_q;
            since_step_q <= 20'h00001;
        end
        else if (since_step_q != STEP_CNT_MAX)
        begin
            since_step_q <= since_step_q + 20'h00001;
            // a stopped motor must not keep an old fast interval
            if (since_step_q >= interval_q)
                interval_q <= since_step_q + 20'h00001;
        end
    end

    assign step_interval_count_out = interval_q;

    // ----------------------------------------
    // shadowed settings, changed only at a period boundary
    // ----------------------------------------
    logic [3:0] lim_q;
    logic [1:0] ss_opt_q;
    logic [3:0] off_time_setting_q;

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            lim_q    <= LIM_RESET;
            ss_opt_q <= SS_NORMAL;
            off_time_setting_q   <= 4'h0;
        end
        else if (boundary)
        begin
            lim_q    <= amplitude_limit_in;
            ss_opt_q <= standstill_option_in;
            off_time_setting_q   <= off_time_setting_in;
        end
    end

    assign driver_enable_out = off_time_setting_q != 4'h0;

    // ----------------------------------------
    // chopper mode select
    // ----------------------------------------
    vpc_mode_t mode_q;
    vpc_mode_t mode_d;
    logic      fast;

    assign fast = (mode_switch_threshold_in != 20'h00000)
                  && (interval_q < mode_switch_threshold_in);

    always_comb
    begin
        if ((global_spread_cfg_in ^ spread_sync_q[1]) | fast)
            mode_d = VPC_CURR;
        else
            mode_d = VPC_VOLT;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            mode_q <= VPC_VOLT;
        else if (boundary)
            mode_q <= mode_d;
    end

    assign current_mode_out = mode_q == VPC_CURR;

    // ----------------------------------------
    // current regulator, correction held at twice its value
    // ----------------------------------------
    logic [9:0]  corr2_q;
    logic [9:0]  corr2_d;
    logic        reg_run;
    logic        below;

    assign below   = |coil_below_target_in;
    assign reg_run = fullstep_in && autoscale_in && (mode_q == VPC_VOLT)
                     && !target_current_zero_in;

    always_comb
    begin
        corr2_d = corr2_q;
        if (below)
        begin
            corr2_d = corr2_q + {6'h00, regulation_gradient_in};
            if ($signed(corr2_d) > $signed(CORR2_MAX) || $signed(corr2_d) < $signed(corr2_q))
                corr2_d = CORR2_MAX;
        end
        else
        begin
            corr2_d = corr2_q - {6'h00, regulation_gradient_in};
            if ($signed(corr2_d) < $signed(CORR2_MIN) || $signed(corr2_d) > $signed(corr2_q))
                corr2_d = CORR2_MIN;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            corr2_q <= 10'h000;
        else if (reg_run)
            corr2_q <= corr2_d;
    end

    assign scale_correction_out = corr2_q[9:1];

    // ----------------------------------------
    // automatic tuning of gradient and offset
    // ----------------------------------------
    logic [7:0] tgrad_q;
    logic [7:0] tofs_q;
    logic       still;

    assign still = interval_q == STEP_CNT_MAX;

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            tgrad_q <= GRAD_INIT;
        else if (!autograd_in)
            tgrad_q <= amplitude_gradient_in;
        else if (reg_run && !still)
        begin
            if (!corr2_q[9] && corr2_q != 10'h000 && tgrad_q != SCALE_MAX)
                tgrad_q <= tgrad_q + 8'h01;
            else if (corr2_q[9] && tgrad_q != 8'h00)
                tgrad_q <= tgrad_q - 8'h01;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            tofs_q <= OFS_RESET;
        else if (!autoscale_in)
            tofs_q <= amplitude_offset_in;
        else if (reg_run && still)
        begin
            if (!corr2_q[9] && corr2_q != 10'h000 && tofs_q != SCALE_MAX)
                tofs_q <= tofs_q + 8'h01;
            else if (corr2_q[9] && tofs_q != 8'h00)
                tofs_q <= tofs_q - 8'h01;
        end
    end

    assign tuned_gradient_readback_out = tgrad_q;
    assign tuned_offset_readback_out   = tofs_q;

    // ----------------------------------------
    // amplitude: offset + gradient * 256 / interval, approximated by shift
    // ----------------------------------------
    logic [4:0]  msb_pos;
    logic [15:0] vel_term;
    logic [10:0] sum_raw;
    logic [7:0]  sum_q;
    logic [7:0]  ofs_sel;
    logic [7:0]  grad_sel;
    logic [12:0] cur_scaled;
    logic [7:0]  amp_d;
    logic [7:0]  lim_full;
    logic        lim_act_q;

    always_comb
    begin
        msb_pos = 5'h00;
        for (int i = 0; i < THR_W; i++)
            if (interval_q[i])
                msb_pos = 5'(i);
    end

    assign ofs_sel  = autoscale_in ? tofs_q : amplitude_offset_in;
    assign grad_sel = autoscale_in ? tgrad_q : amplitude_gradient_in;
    assign vel_term = {grad_sel, 8'h00} >> msb_pos;

    always_comb
    begin
        sum_raw = {3'h0, ofs_sel} + {3'h0, vel_term[7:0]}
                  + ((vel_term[15:8] != 8'h00) ? 11'h100 : 11'h000);
        if (autoscale_in)
            sum_raw = sum_raw + {{2{corr2_q[9]}}, corr2_q[9:1]};
        if (sum_raw[10])
            sum_raw = 11'h000;
        else if (sum_raw[9:8] != 2'h0)
            sum_raw = {3'h0, SCALE_MAX};
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            sum_q <= 8'h00;
        else if (mode_q == VPC_VOLT)
            sum_q <= sum_raw[7:0];
    end

    assign scale_sum_out = sum_q;
    assign lim_full      = {lim_q, LIM_LOW_FILL};

    // zero offset skips current-setting scaling so forward mode stays linear
    assign cur_scaled = {5'h00, sum_q} * ({8'h00, current_setting_in} + 13'h0001);

    always_comb
    begin
        amp_d = (amplitude_offset_in == 8'h00) ? sum_q : cur_scaled[12:5];
        if (lim_act_q && amp_d > lim_full)
            amp_d = lim_full;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            lim_act_q <= 1'b0;
        else if (boundary && mode_q == VPC_CURR && mode_d == VPC_VOLT)
            lim_act_q <= 1'b1;
        else if (fullstep_in)
            lim_act_q <= 1'b0;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            pwm_amplitude_out <= 8'h00;
        else
            pwm_amplitude_out <= amp_d;
    end

    // ----------------------------------------
    // standstill option after power-down and ramp delays
    // ----------------------------------------
    logic [$clog2(PD_TICK+1)-1:0] tick_q;
    logic [9:0]                   idle_q;
    logic                         ss_ready;

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tick_q <= '0;
            idle_q <= 10'h000;
        end
        else if (step_evt)
        begin
            tick_q <= '0;
            idle_q <= 10'h000;
        end
        else if (tick_q == ($clog2(PD_TICK+1))'(PD_TICK - 1))
        begin
            tick_q <= '0;
            if (idle_q != 10'h3FF)
                idle_q <= idle_q + 10'h001;
        end
        else
            tick_q <= tick_q + ($clog2(PD_TICK+1))'(1);
    end

    assign ss_ready = idle_q >= ({2'h0, power_down_delay_in}
                      + {6'h00, hold_ramp_delay_in} + 10'h001);

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            standstill_out <= SS_NORMAL;
        else if (hold_current_in == 5'h00 && mode_q == VPC_VOLT && ss_ready)
            standstill_out <= ss_opt_q;
        else
            standstill_out <= SS_NORMAL;
    end

    // ----------------------------------------
    // open-load detection per coil
    // ----------------------------------------
    logic [1:0] ol_flag;

    for (genvar c = 0; c < 2; c++)
    begin : g_coil
        logic [2:0] miss_q;
        always_ff @(posedge ref_clk_in or posedge rst_in)
        begin
            if (rst_in)
                miss_q <= 3'h0;
            else if (fullstep_in && mode_q == VPC_VOLT)
            begin
                if (!coil_below_target_in[c])
                    miss_q <= 3'h0;
                else if (miss_q != OL_FULLSTEPS)
                    miss_q <= miss_q + 3'h1;
            end
        end
        assign ol_flag[c] = coil_interrupted_in[c]
                            || (mode_q == VPC_VOLT && miss_q == OL_FULLSTEPS);
    end

    assign open_load_coil_a_out = ol_flag[0];
    assign open_load_coil_b_out = ol_flag[1];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence mode_req_curr;
        boundary && mode_d == VPC_CURR;
    endsequence

    mode_select_a: assert property (mode_req_curr |=> current_mode_out)
        else $error("current mode not taken at boundary");
    zero_thr_a: assert property (boundary && mode_switch_threshold_in == 20'h00000
        && !(global_spread_cfg_in ^ spread_sync_q[1]) |=> !current_mode_out)
        else $error("zero threshold left voltage mode");
    corr_frozen_a: assert property (current_mode_out && $past(current_mode_out)
        |-> $stable(scale_correction_out))
        else $error("correction moved in current mode");
    // forward scaling past 255 must clamp, never wrap
    sum_sat_a: assert property (mode_q == VPC_VOLT && !autoscale_in
        && vel_term[15:8] != 8'h00 |=> scale_sum_out == SCALE_MAX)
        else $error("scale sum not saturated");
    drv_enable_a: assert property (boundary
        |=> driver_enable_out == ($past(off_time_setting_in) != 4'h0))
        else $error("driver enable mismatch");
    ss_gate_a: assert property (standstill_out != SS_NORMAL |-> $past(ss_ready)
        && $past(hold_current_in) == 5'h00)
        else $error("standstill option applied early");
    open_load_a: assert property (coil_interrupted_in != 2'b00
        |-> ({open_load_coil_b_out, open_load_coil_a_out} & coil_interrupted_in)
            == coil_interrupted_in)
        else $error("open load flag missing on interrupted coil");
    lim_clamp_a: assert property (lim_act_q |=> pwm_amplitude_out <= $past(lim_full))
        else $error("amplitude exceeded limit after mode return");
    freeze_a: assert property (target_current_zero_in |=> $stable(corr2_q))
        else $error("regulation moved at zero target");
endmodule // vpc_chopper_ctrl

// ==== testbench/vpc_coil_model.sv ====
// vpc_coil_model: coil pair behind the bridges, paces fullsteps
// assumes: bench clock; fault inputs are set by the bench
`timescale 1ns/1ps
module vpc_coil_model
(
    input  wire logic       ref_clk_in,
    input  wire logic [1:0] weak_in,
    input  wire logic [1:0] broken_in,
    output logic            fullstep_out,
    output logic [1:0]      below_out,
    output logic [1:0]      intr_out
);
    int c = 0;
    // an open coil never reaches its target either
    assign below_out = weak_in | broken_in;
    assign intr_out = broken_in;
    always @(posedge ref_clk_in)
    begin
        c <= (c + 1) % 50;
        fullstep_out <= c == 49;
    end
endmodule // vpc_coil_model

// ==== testbench/vpc_chopper_ctrl_tb.sv ====
// vpc_chopper_ctrl_tb: self-checking bench of the chopper control
// assumes: vpc_coil_model paces fullsteps and plays coil faults
`timescale 1ns/1ps
module vpc_chopper_ctrl_tb;
    import vpc_pkg::*;
    // tuning enabled at start so the readbacks keep their reset values
    logic clk = 0, rst = 1, cfg = 0, pin = 0, stp = 0, az = 1, ag = 1, tz = 0;
    logic [7:0] ssm, amp;
    logic [8:0] corr;
    logic [19:0] thr = 0, ivl;
    logic [3:0] lim = 0, rg = 1, pdr = 0, tof = 1;
    logic [7:0] ofs = 0, grd = 0, pd = 0, tg, to;
    logic [1:0] fs = 0, ss = 0, blank_time_select = 0, wk = 0, brk = 0, blw, itr, sso;
    logic [4:0] hc = 1, cs = 0;
    logic fst, cm, den, ch, bl, open_load_coil_a, open_load_coil_b;
    logic [31:0] sd = 32'h0000004F;
    logic [10:0] dv [4] = '{PWM_DIV_0, PWM_DIV_1, PWM_DIV_2, PWM_DIV_3};
    int n_errors = 0, n_compared = 0, cyc = 0, k, m, p, s;
    vpc_chopper_ctrl #(.PD_TICK(4)) dut_u (.ref_clk_in(clk), .rst_in(rst),
        .global_spread_cfg_in(cfg), .spread_pin_in(pin), .step_pin_in(stp),
        .fullstep_in(fst), .mode_switch_threshold_in(thr), .amplitude_limit_in(lim),
        .autoscale_in(az), .autograd_in(ag), .pwm_frequency_select_in(fs),
        .regulation_gradient_in(rg), .amplitude_offset_in(ofs),
        .amplitude_gradient_in(grd), .standstill_option_in(ss), .hold_current_in(hc),
        .current_setting_in(cs), .target_current_zero_in(tz), .power_down_delay_in(pd),
        .hold_ramp_delay_in(pdr), .off_time_setting_in(tof), .blank_time_select_in(blank_time_select),
        .coil_below_target_in(blw), .coil_interrupted_in(itr), .current_mode_out(cm),
        .driver_enable_out(den), .chopper_out(ch), .blank_out(bl), .standstill_out(sso),
        .open_load_coil_a_out(open_load_coil_a), .open_load_coil_b_out(open_load_coil_b), .scale_correction_out(corr),
        .tuned_gradient_readback_out(tg), .tuned_offset_readback_out(to),
        .scale_sum_out(ssm), .pwm_amplitude_out(amp), .step_interval_count_out(ivl));
    vpc_coil_model cm_u (.ref_clk_in(clk), .weak_in(wk), .broken_in(brk),
        .fullstep_out(fst), .below_out(blw), .intr_out(itr));
    initial forever #2.5 clk = ~clk;
    function automatic logic [31:0] rnd();
        sd ^= sd << 13;
        sd ^= sd >> 17;
        sd ^= sd << 5;
        return sd;
    endfunction
    function automatic logic md(logic c, logic p, int t, int v);
        return (c ^ p) | (t != 0 && v < t);
    endfunction
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(logic [19:0] seen, logic [19:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    // waits n chopper toggles; k ends as the length of the last one
    task automatic bnd(int n);
        repeat (n)
        begin
            m = ch;
            for (k = 0; k < 1100 && ch === m; k++) tick(1);
        end
    endtask
    task automatic rcfg();
        {az, ag, tz, ofs, grd, ss, cs} = 26'(rnd());
        {lim, pdr, pd} = 16'(rnd());
        rg = 4'(1 + rnd() % 15);
        hc = 5'(1 + rnd() % 31);
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // cut a hang short well beyond the expected run length
    always @(posedge clk)
        if (++cyc == 30000)
        begin
            n_errors++;
            summarize();
        end
    initial
    begin
        tick(5);
        rst = 0;
        tick(1);
        chk(ivl, STEP_CNT_MAX);
        chk(tg, GRAD_RESET);
        chk(to, OFS_RESET);
        chk(corr, 9'h000);
        chk(amp, 8'h00);
        // two toggles make one full period, also for the fractional code 1
        for (s = 0; s < 4; s++)
        begin
            fs = 2'(s);
            bnd(3);
            p = k;
            bnd(1);
            chk(20'(p + k), 20'(dv[s]));
        end
        $display("period test done");
        fs = 2'h2;
        for (s = 0; s < 4; s++)
        begin
            blank_time_select = 2'(s);
            tof = s ? 4'(1 + rnd() % 15) : 4'h0;
            rcfg();
            bnd(2);
            chk(den, s != 0);
            for (k = 0; k < 99 && bl === 1'b1; k++) tick(1);
            chk(20'(k), 20'(BLANK_BASE + BLANK_STEP * s));
        end
        $display("blank test done");
        for (s = 0; s < 5; s++)
        begin
            {cfg, pin} = 2'(s);
            tick(3);
            bnd(2);
            chk(cm, md(cfg, pin, 0, 0));
        end
        $display("mode test done");
        // forward scaling with a large gradient at 100-cycle steps overflows 255
        az = 0;
        grd = 8'hC0;
        ofs = 8'h80;
        cs = 5'h1F;
        for (s = 0; s < 2; s++)
        begin
            thr = s ? 20'h003E8 : 20'h00000;
            repeat (4)
            begin
                tick(50);
                stp = 1;
                tick(50);
                stp = 0;
            end
            chk(ivl, 20'h00064);
            if (s == 0)
            begin
                chk(ssm, SCALE_MAX);
                chk(amp, SCALE_MAX);
            end
            bnd(1);
            chk(cm, md(0, 0, thr, 100));
        end
        $display("threshold test done");
        thr = 0;
        bnd(1);
        wk = 2'h1;
        tick(260);
        chk({open_load_coil_a, open_load_coil_b}, 2'h2);
        brk = 2'h2;
        tick(1);
        chk(open_load_coil_b, 1'b1);
        {wk, brk} = 4'h0;
        tick(260);
        chk({open_load_coil_a, open_load_coil_b}, 2'h0);
        hc = 0;
        tick(1300);
        chk(sso, ss);
        $display("open load and standstill test done");
        summarize();
    end
endmodule // vpc_chopper_ctrl_tb
